// file: sps_pkg.sv
// Purpose: shared constants and types for the stepper phase sequencer
// Assumes: ref_clk at 200 MHz; 32-bit Avalon-MM register bus, word aligned
// Notes: 64-position electrical cycle, two positions per finest micro step
package sps_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_FREQ_MHZ = 200;
   localparam int unsigned BLANK_TIME_NS = 1250; // overcurrent dead time
   // least time, so round up to whole cycles
   localparam int unsigned BLANK_CYCLES = (BLANK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned CHOP_W = 16;
   localparam logic [CHOP_W-1:0] BLANK_CNT = CHOP_W'(BLANK_CYCLES);
   localparam logic [CHOP_W-1:0] CHOP_RST = 16'h0fa0; // 20 us chopping period

   // ****************************************************************
   // phase distributor
   // ****************************************************************
   localparam int unsigned POS_W = 6;
   localparam logic [POS_W-1:0] POS_INIT = 6'h08; // a+b both on
   localparam int unsigned POS_HALF_BIT = 5;
   typedef enum logic [1:0] {
      SPS_MODE_2PH = 2'b00,
      SPS_MODE_12 = 2'b01,
      SPS_MODE_W12 = 2'b10,
      SPS_MODE_2W12 = 2'b11
   } sps_mode_type;
   localparam logic [POS_W-1:0] INC_2PH = 6'h10;
   localparam logic [POS_W-1:0] INC_12 = 6'h08;
   localparam logic [POS_W-1:0] INC_W12 = 6'h04;
   localparam logic [POS_W-1:0] INC_2W12 = 6'h02;
   // conduction windows of each winding over the electrical cycle
   localparam logic [POS_W-1:0] A_ON_FROM = 6'h31;
   localparam logic [POS_W-1:0] A_ON_TO = 6'h0f;
   localparam logic [POS_W-1:0] AB_ON_FROM = 6'h11;
   localparam logic [POS_W-1:0] AB_ON_TO = 6'h2f;
   localparam logic [POS_W-1:0] B_ON_FROM = 6'h01;
   localparam logic [POS_W-1:0] B_ON_TO = 6'h1f;
   localparam logic [POS_W-1:0] BB_ON_FROM = 6'h21;
   localparam logic [POS_W-1:0] BB_ON_TO = 6'h3f;
   localparam logic [3:0] DRV_OFF = 4'h0;

   // ****************************************************************
   // fault kind codes
   // ****************************************************************
   localparam logic [1:0] KIND_NONE = 2'h0;
   localparam logic [1:0] KIND_OC = 2'h1; // about 2.5 V level
   localparam logic [1:0] KIND_OT = 2'h2; // about 3.3 V level

   // ****************************************************************
   // registers
   // ****************************************************************
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam int unsigned ST_POS_LSB = 0;
   localparam int unsigned ST_EN_BIT = 6;
   localparam int unsigned ST_OC_BIT = 7;
   localparam int unsigned ST_OT_BIT = 8;
   localparam int unsigned ST_MODE_LSB = 9;
   localparam int unsigned ST_DIR_BIT = 11;
   localparam int unsigned ST_EDGE_BIT = 12;
   localparam int unsigned N_PINS = 9;
endpackage

// file: sps_prot_if.sv
// Purpose: carrier between the sequencer core and its protection unit
// Assumes: all signals on ref_clk
// Notes: the protection unit drives only the latch outputs
`timescale 1ns/10ps
interface sps_prot_if;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic sys_rst;
   logic run_en;
   logic oc_raw;
   logic ot_raw;
   logic [sps_pkg::CHOP_W-1:0] chop_period;
   logic oc_latch;
   logic ot_latch;

   modport unit (
      input sys_rst, run_en, oc_raw, ot_raw, chop_period,
      output oc_latch, ot_latch
   );
   modport core (
      output sys_rst, run_en, oc_raw, ot_raw, chop_period,
      input oc_latch, ot_latch
   );
endinterface

// file: sps_prot_unit.sv
// Purpose: overcurrent blanking and latched overcurrent / overheat detection
// Assumes: inputs already synchronised to ref_clk
// Notes: latches clear only through system reset
`timescale 1ns/10ps
module sps_prot_unit (
   // clock
   input wire logic ref_clk,
   // link to the core
   sps_prot_if.unit prot
);
   import sps_pkg::*;

   logic [CHOP_W-1:0] chop_cnt_ff;
   logic in_blank;

   // ****************************************************************
   // chopping period and blanking
   // ****************************************************************
   // period counter restarts each chopping period; frozen while disabled
   always_ff @(posedge ref_clk) begin
      if (prot.sys_rst) begin
         chop_cnt_ff <= '0;
      end else if (prot.run_en) begin
         if (chop_cnt_ff >= prot.chop_period - CHOP_W'(1)) begin
            chop_cnt_ff <= '0;
         end else begin
            chop_cnt_ff <= chop_cnt_ff + CHOP_W'(1);
         end
      end
   end

   // ringing after each period start is never judged
   assign in_blank = chop_cnt_ff < BLANK_CNT; // R16

   // ****************************************************************
   // fault latches
   // ****************************************************************
   // once set a latch holds until reset, even if the cause goes away
   always_ff @(posedge ref_clk) begin
      if (prot.sys_rst) begin
         prot.oc_latch <= 1'b0; // R15 R20
      end else if (prot.run_en && prot.oc_raw && !in_blank) begin
         prot.oc_latch <= 1'b1; // R14 R16
      end
   end

   always_ff @(posedge ref_clk) begin
      if (prot.sys_rst) begin
         prot.ot_latch <= 1'b0; // R15 R20
      end else if (prot.run_en && prot.ot_raw) begin
         prot.ot_latch <= 1'b1; // R14
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_blank_ignore;
      @(posedge ref_clk) disable iff (prot.sys_rst)
      (!prot.oc_latch && in_blank) |=> !prot.oc_latch;
   endproperty
   a_blank_ignore: assert property (p_blank_ignore) // R16
      else $error("overcurrent latched inside blanking window");

   property p_oc_hold;
      @(posedge ref_clk) disable iff (prot.sys_rst)
      prot.oc_latch |=> prot.oc_latch [*4];
   endproperty
   a_oc_hold: assert property (p_oc_hold) // R15
      else $error("overcurrent latch cleared without reset");
endmodule

// file: sps_stepper_top.sv
// Purpose: phase distributor, enable gating and fault outputs of a stepper driver
// Assumes: pin inputs asynchronous to ref_clk; reset is the power-on reset
// Notes: registers reached over Avalon-MM with waitrequest
`timescale 1ns/10ps
// Notes on behaviour
// R1 - edge_sel 1: step on rising edges only
// R2 - edge_sel 0: step on both edges
// R3 - controller keeps step rate within limits
// R4 - rotation_dir 0 clockwise, 1 counterclockwise
// R5 - controller holds direction 7 us around edges
// R6 - enable low forces all drive outputs off
// R7 - enable low freezes state, ignores inputs; pin reset and register writes still act while disabled
// R8 - controller holds mode pins around edges
// R9 - system reset from power-on or pin
// R10 - controller keeps enable low at low supply
// R11 - controller waits 10 us after reset
// R12 - fault flag pulled low on any fault
// R13 - fault kind output tells overcurrent from overheat
// R14 - detections latch and switch drive off
// R15 - only reset clears fault latches
// R16 - overcurrent ignored during 1.25 us blanking
// R17 - monitor output rate follows excitation mode
// R18 - mode and edge choice taken from pins
// R19 - controller slows step clock to stop
// R20 - reset sets initial phase, clears faults
module sps_stepper_top #(
   parameter logic [sps_pkg::CHOP_W-1:0] CHOP_DEFAULT = sps_pkg::CHOP_RST
) (
   // clock and power-on reset
   input wire logic ref_clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [sps_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // controller pins
   input wire logic step_clk,
   input wire logic rotation_dir,
   input wire logic excite_sel_a,
   input wire logic excite_sel_b,
   input wire logic edge_sel,
   input wire logic out_enable,
   input wire logic sys_rst_n,
   // protection sense inputs
   input wire logic oc_cmp,
   input wire logic ot_det,
   // excitation drive
   output logic drv_a,
   output logic drv_ab,
   output logic drv_b,
   output logic drv_bb,
   // fault and monitor outputs
   output logic prot_flag_n_o,
   output logic prot_flag_n_oe,
   output logic [1:0] prot_kind_level,
   output logic phase_monitor_out
);
   import sps_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [N_PINS-1:0] pin_raw;
   logic [N_PINS-1:0] sync1_ff;
   logic [N_PINS-1:0] sync2_ff;
   logic step_prev_ff;
   logic step_s, dir_s, sel_a_s, sel_b_s, edge_s, en_s, rst_n_s, oc_s, ot_s;
   logic sys_rst_ff;
   logic step_rise, step_fall, step_ev;
   sps_mode_type mode;
   logic [POS_W-1:0] pos_ff;
   logic [POS_W-1:0] step_inc;
   logic fault;
   logic [3:0] drv_ff;
   logic flag_ff;
   logic flag_n_ff;
   logic [1:0] kind_ff;
   logic mon_ff;
   logic [CHOP_W-1:0] ctrl_ff;
   logic [31:0] rdata_ff;
   logic wait_ff;
   logic bus_req;
   sps_prot_if prot ();

   // ****************************************************************
   // functions
   // ****************************************************************
   // true when pos lies in the circular window from..to
   function automatic logic in_window(input logic [POS_W-1:0] pos,
                                      input logic [POS_W-1:0] from,
                                      input logic [POS_W-1:0] to);
      logic res;
      res = 1'b0;
      if (from <= to) begin
         res = (pos >= from) && (pos <= to);
      end else begin
         res = (pos >= from) || (pos <= to);
      end
      return res;
   endfunction

   // drive pattern {bb, b, ab, a} for one position
   function automatic logic [3:0] drive_pattern(input logic [POS_W-1:0] pos);
      logic [3:0] pat;
      pat = DRV_OFF;
      pat[0] = in_window(pos, A_ON_FROM, A_ON_TO);
      pat[1] = in_window(pos, AB_ON_FROM, AB_ON_TO);
      pat[2] = in_window(pos, B_ON_FROM, B_ON_TO);
      pat[3] = in_window(pos, BB_ON_FROM, BB_ON_TO);
      return pat;
   endfunction

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   assign pin_raw = {ot_det, oc_cmp, sys_rst_n, out_enable, edge_sel,
                     excite_sel_b, excite_sel_a, rotation_dir, step_clk};

   // two flops per pin; only the second stage is read by logic
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
      end
   end

   assign step_s = sync2_ff[0];
   assign dir_s = sync2_ff[1];
   assign sel_a_s = sync2_ff[2];
   assign sel_b_s = sync2_ff[3];
   assign edge_s = sync2_ff[4];
   assign en_s = sync2_ff[5];
   assign rst_n_s = sync2_ff[6];
   assign oc_s = sync2_ff[7];
   assign ot_s = sync2_ff[8];

   // ****************************************************************
   // system reset
   // ****************************************************************
   // pin reset is honoured even while disabled
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sys_rst_ff <= 1'b1;
      end else begin
         sys_rst_ff <= !rst_n_s; // R9
      end
   end

   // ****************************************************************
   // step edge detection
   // ****************************************************************
   // the previous sample tracks the pin even while disabled so that
   // re-enabling never produces a phantom step
   always_ff @(posedge ref_clk) begin
      if (sys_rst_ff) begin
         step_prev_ff <= step_s; // a pin idling high must not look like an edge
      end else begin
         step_prev_ff <= step_s;
      end
   end

   assign step_rise = step_s && !step_prev_ff;
   assign step_fall = !step_s && step_prev_ff;
   // single edge or both edges, ignored while disabled
   assign step_ev = en_s && (step_rise || (!edge_s && step_fall)); // R1 R2 R7 R18

   // ****************************************************************
   // phase distributor
   // ****************************************************************
   assign mode = sps_mode_type'({sel_b_s, sel_a_s}); // R18

   // step size per mode; the position itself is kept across mode changes
   always_comb begin
      case (mode)
         SPS_MODE_2PH: step_inc = INC_2PH;
         SPS_MODE_12: step_inc = INC_12;
         SPS_MODE_W12: step_inc = INC_W12;
         SPS_MODE_2W12: step_inc = INC_2W12;
         default: step_inc = INC_2PH;
      endcase
   end

   // a fault stops stepping too, so the phase is kept for diagnosis
   always_ff @(posedge ref_clk) begin
      if (sys_rst_ff) begin
         pos_ff <= POS_INIT; // R20
      end else if (step_ev && !fault) begin
         if (dir_s) begin
            pos_ff <= pos_ff - step_inc; // R4
         end else begin
            pos_ff <= pos_ff + step_inc; // R4
         end
      end
   end

   // ****************************************************************
   // protection
   // ****************************************************************
   assign prot.sys_rst = sys_rst_ff;
   assign prot.run_en = en_s; // R7
   assign prot.oc_raw = oc_s;
   assign prot.ot_raw = ot_s;
   assign prot.chop_period = ctrl_ff;
   assign fault = prot.oc_latch || prot.ot_latch;

   sps_prot_unit u_prot (
      .ref_clk(ref_clk),
      .prot(prot)
   );

   // ****************************************************************
   // outputs
   // ****************************************************************
   // drive follows position; off while disabled or after a fault
   always_ff @(posedge ref_clk) begin
      if (sys_rst_ff) begin
         drv_ff <= DRV_OFF;
      end else if (!en_s || fault) begin
         drv_ff <= DRV_OFF; // R6 R14
      end else begin
         drv_ff <= drive_pattern(pos_ff);
      end
   end

   // open drain flag and fault kind; overheat shown when both are set
   always_ff @(posedge ref_clk) begin
      if (sys_rst_ff) begin
         flag_ff <= 1'b0;
         flag_n_ff <= 1'b1;
         kind_ff <= KIND_NONE;
      end else begin
         flag_ff <= fault; // R12
         flag_n_ff <= !fault; // R12
         if (prot.ot_latch) begin
            kind_ff <= KIND_OT; // R13
         end else if (prot.oc_latch) begin
            kind_ff <= KIND_OC; // R13
         end else begin
            kind_ff <= KIND_NONE;
         end
      end
   end

   // monitor is high in the first half of the electrical cycle, so its
   // rate per step clock shrinks as the step size shrinks
   always_ff @(posedge ref_clk) begin
      if (sys_rst_ff) begin
         mon_ff <= 1'b0;
      end else begin
         mon_ff <= !pos_ff[POS_HALF_BIT]; // R17
      end
   end

   assign drv_a = drv_ff[0];
   assign drv_ab = drv_ff[1];
   assign drv_b = drv_ff[2];
   assign drv_bb = drv_ff[3];
   assign prot_flag_n_o = flag_n_ff;
   assign prot_flag_n_oe = flag_ff;
   assign prot_kind_level = kind_ff;
   assign phase_monitor_out = mon_ff;

   // ****************************************************************
   // register bus
   // ****************************************************************
   assign bus_req = avs_read || avs_write;

   // one wait cycle per access, then a single-cycle acknowledge
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= !(bus_req && wait_ff);
      end
   end

   // read data captured while waitrequest is still high; unmapped reads zero
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_ff <= '0;
      end else if (avs_read && wait_ff) begin
         rdata_ff <= '0;
         case (avs_address)
            REG_CTRL: rdata_ff[CHOP_W-1:0] <= ctrl_ff;
            REG_STATUS: begin
               rdata_ff[ST_POS_LSB +: POS_W] <= pos_ff;
               rdata_ff[ST_EN_BIT] <= en_s;
               rdata_ff[ST_OC_BIT] <= prot.oc_latch;
               rdata_ff[ST_OT_BIT] <= prot.ot_latch;
               rdata_ff[ST_MODE_LSB +: 2] <= mode;
               rdata_ff[ST_DIR_BIT] <= dir_s;
               rdata_ff[ST_EDGE_BIT] <= edge_s;
            end
            default: rdata_ff <= '0;
         endcase
      end
   end

   // chopping period; writes land on the acknowledge edge only
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_ff <= CHOP_DEFAULT;
      end else if (avs_write && !wait_ff && avs_address == REG_CTRL) begin
         if (avs_byteenable[0]) begin
            ctrl_ff[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            ctrl_ff[15:8] <= avs_writedata[15:8];
         end
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_rise_only;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      (edge_s && step_fall && !step_rise) |=> $stable(pos_ff);
   endproperty
   a_rise_only: assert property (p_rise_only) // R1
      else $error("falling edge stepped in single edge mode");

   property p_both_edges;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      (en_s && !edge_s && step_fall && !fault) |=> !$stable(pos_ff);
   endproperty
   a_both_edges: assert property (p_both_edges) // R2
      else $error("falling edge missed in both edge mode");

   property p_cw_step;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      (step_ev && !fault && !dir_s && mode == SPS_MODE_W12)
         |=> pos_ff == $past(pos_ff) + INC_W12;
   endproperty
   a_cw_step: assert property (p_cw_step) // R4
      else $error("clockwise step size wrong");

   property p_ccw_step;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      (step_ev && !fault && dir_s && mode == SPS_MODE_2PH)
         |=> pos_ff == $past(pos_ff) - INC_2PH;
   endproperty
   a_ccw_step: assert property (p_ccw_step) // R4
      else $error("counterclockwise step wrong");

   property p_enable_off;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      !en_s |=> (drv_a || drv_ab || drv_b || drv_bb) == 1'b0;
   endproperty
   a_enable_off: assert property (p_enable_off) // R6
      else $error("drive on while disabled");

   property p_freeze;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      (!en_s ##1 !en_s) |-> $stable(pos_ff) && $stable(prot.oc_latch);
   endproperty
   a_freeze: assert property (p_freeze) // R7
      else $error("state changed while disabled");

   property p_pin_reset;
      @(posedge ref_clk) disable iff (reset)
      !rst_n_s |=> ##1 (pos_ff == POS_INIT && !prot_flag_n_oe);
   endproperty
   a_pin_reset: assert property (p_pin_reset) // R9 R20
      else $error("pin reset did not restore initial state");

   property p_flag;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      fault |=> (prot_flag_n_oe && !prot_flag_n_o) [*2];
   endproperty
   a_flag: assert property (p_flag) // R12
      else $error("fault flag not pulled low");

   property p_kind;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      (prot.oc_latch && !prot.ot_latch) |=> prot_kind_level == KIND_OC;
   endproperty
   a_kind: assert property (p_kind) // R13
      else $error("overcurrent kind level wrong");

   property p_fault_off;
      @(posedge ref_clk) disable iff (sys_rst_ff)
      fault |=> (drv_ff == DRV_OFF && fault) [*3];
   endproperty
   a_fault_off: assert property (p_fault_off) // R14 R15
      else $error("drive on after fault latch");
endmodule

// file: sps_ctrl_model.sv
// Purpose: motion controller model driving the stepper pins
// Assumes: ref_clk at 200 MHz
// Notes: keeps every pin timing margin of the controller side
`timescale 1ns/10ps
module sps_ctrl_model #(
   parameter int HOLD = 1400, // 7 us
   parameter int HALF = 5000 // 25 us between step edges
) (
   // clock
   input wire logic ref_clk,
   // controller pins
   output logic step_clk,
   output logic rotation_dir,
   output logic excite_sel_a,
   output logic excite_sel_b,
   output logic edge_sel,
   output logic out_enable,
   output logic sys_rst_n
);
   // enable starts low so outputs stay dead while supply ramps
   initial begin
      step_clk = 1'b0;
      rotation_dir = 1'b0;
      {excite_sel_b, excite_sel_a, edge_sel} = 3'h1;
      out_enable = 1'b0;
      sys_rst_n = 1'b1;
   end
   // settings move only far from any step edge
   task automatic setup(input logic dir, input logic [1:0] mode, input logic edg);
      @(posedge ref_clk);
      rotation_dir <= dir;
      {excite_sel_b, excite_sel_a} <= mode;
      edge_sel <= edg;
      repeat (HOLD) @(posedge ref_clk);
   endtask
   // one step edge, then a pause long enough for either edge mode;
   // single slow steps mean the motor is never halted from speed
   task automatic edge_once();
      @(posedge ref_clk);
      step_clk <= ~step_clk;
      repeat (HALF) @(posedge ref_clk);
   endtask
   // enable change, kept clear of step edges
   task automatic en(input logic v);
      @(posedge ref_clk);
      out_enable <= v;
      repeat (HOLD) @(posedge ref_clk);
   endtask
   // high-low-high pulse, then 10 us before any step edge
   task automatic rst();
      @(posedge ref_clk);
      sys_rst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      sys_rst_n <= 1'b1;
      repeat (2000) @(posedge ref_clk);
   endtask
endmodule

// file: sps_stepper_top_test.sv
// Purpose: self-checking bench of the stepper sequencer
// Assumes: controller model on the pins, bench on the register bus
// Notes: chopping period shortened to 400 cycles for blanking checks
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
module sps_stepper_top_test;
   import sps_pkg::*;
   logic ref_clk, reset, avs_read, avs_write, oc_cmp, ot_det;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic avs_waitrequest, step_clk, rotation_dir, excite_sel_a, excite_sel_b;
   logic edge_sel, out_enable, sys_rst_n, drv_a, drv_ab, drv_b, drv_bb;
   logic prot_flag_n_o, prot_flag_n_oe, phase_monitor_out, flag_line;
   logic [1:0] prot_kind_level;
   int bad_count = 0;
   int tests_run = 0;
   // open-drain line with pull-up
   assign flag_line = prot_flag_n_oe ? 1'b0 : 1'b1;
   sps_ctrl_model ctl (.ref_clk(ref_clk), .step_clk(step_clk), .rotation_dir(rotation_dir),
      .excite_sel_a(excite_sel_a), .excite_sel_b(excite_sel_b), .edge_sel(edge_sel),
      .out_enable(out_enable), .sys_rst_n(sys_rst_n));
   sps_stepper_top dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .step_clk(step_clk), .rotation_dir(rotation_dir), .excite_sel_a(excite_sel_a),
      .excite_sel_b(excite_sel_b), .edge_sel(edge_sel), .out_enable(out_enable),
      .sys_rst_n(sys_rst_n), .oc_cmp(oc_cmp), .ot_det(ot_det), .drv_a(drv_a),
      .drv_ab(drv_ab), .drv_b(drv_b), .drv_bb(drv_bb), .prot_flag_n_o(prot_flag_n_o),
      .prot_flag_n_oe(prot_flag_n_oe), .prot_kind_level(prot_kind_level),
      .phase_monitor_out(phase_monitor_out));
   // ****************************************************************
   // helpers
   // ****************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      {avs_address, avs_write, avs_read, avs_writedata} <= {adr, wr, !wr, wd};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) bad_count++;
   endtask
   // expected windings {a, ab, b, bb} for a position
   function automatic logic [3:0] exp_drv(input logic [5:0] p);
      return {p >= 6'h31 || p <= 6'h0f, p >= 6'h11 && p <= 6'h2f, p >= 6'h01 && p <= 6'h1f,
         p >= 6'h21};
   endfunction
   task automatic chk_pos(input logic [5:0] p);
      bus(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[5:0], p)
      `CHK({drv_a, drv_ab, drv_b, drv_bb}, exp_drv(p))
      `CHK(phase_monitor_out, p < 6'h20)
   endtask
   task automatic chk_fault(input logic [2:0] exp);
      `CHK({flag_line, prot_kind_level}, exp)
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      ctl.en(1'b1);
      chk_pos(6'h08);
      chk_fault(3'h4);
      bus(1'b1, REG_CTRL, 32'h0000_0190);
      bus(1'b0, REG_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0190)
      bus(1'b0, 4'hc, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   // rising only forward, then both edges in reverse, 2-phase steps of 16
   task automatic t_edges();
      ctl.setup(1'b0, 2'b00, 1'b1);
      ctl.edge_once();
      chk_pos(6'h18);
      ctl.edge_once();
      chk_pos(6'h18);
      ctl.setup(1'b1, 2'b00, 1'b0);
      ctl.edge_once();
      chk_pos(6'h08);
      ctl.edge_once();
      chk_pos(6'h38);
   endtask
   // reverse with fine steps, then W1-2 forward
   task automatic t_dir_mode();
      ctl.setup(1'b1, 2'b11, 1'b1);
      ctl.edge_once();
      chk_pos(6'h36);
      ctl.edge_once();
      chk_pos(6'h36);
      ctl.setup(1'b0, 2'b10, 1'b1);
      ctl.edge_once();
      chk_pos(6'h3a);
   endtask
   // disabled: drive dead and step edges lost, phase kept
   task automatic t_enable();
      ctl.setup(1'b0, 2'b01, 1'b0);
      ctl.en(1'b0);
      `CHK({drv_a, drv_ab, drv_b, drv_bb}, DRV_OFF)
      ctl.edge_once();
      bus(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[6:0], 7'h3a)
      ctl.en(1'b1);
      chk_pos(6'h3a);
   endtask
   // overheat latches past its cause; only a reset pulse clears it
   task automatic t_heat();
      ot_det <= 1'b1;
      repeat (10) @(posedge ref_clk);
      ot_det <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk_fault(3'h2);
      `CHK({drv_a, drv_ab, drv_b, drv_bb}, DRV_OFF)
      ctl.edge_once();
      bus(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[8:0], 9'h17a)
      ctl.rst();
      chk_pos(6'h08);
      chk_fault(3'h4);
   endtask
   // overcurrent early in the period is blanked, later it latches
   task automatic t_blank();
      ctl.rst();
      repeat (30) @(posedge ref_clk);
      oc_cmp <= 1'b1;
      repeat (100) @(posedge ref_clk);
      oc_cmp <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk_fault(3'h4);
      repeat (150) @(posedge ref_clk);
      oc_cmp <= 1'b1;
      repeat (40) @(posedge ref_clk);
      oc_cmp <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk_fault(3'h1);
      `CHK({drv_a, drv_ab, drv_b, drv_bb}, DRV_OFF)
   endtask
   // ****************************************************************
   // run control
   // ****************************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // a hang beyond the expected ~60k cycles ends the run
   initial begin
      repeat (90000) @(posedge ref_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      {reset, avs_read, avs_write, oc_cmp, ot_det} = 5'h10;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (10) @(posedge ref_clk);
      t_reset();
      t_edges();
      t_dir_mode();
      t_enable();
      t_heat();
      t_blank();
      end_of_test();
   end
endmodule
